// ==== pkg/mtc_defines.svh ====
// Register offsets, field positions, reset values and timing constants of the modulo timer
`ifndef MTC_DEFINES_SVH
`define MTC_DEFINES_SVH

// Byte addresses (word aligned, index times four)
`define MTC_IDX_STATUS_CONTROL 2'h0
`define MTC_IDX_CLOCK_CONFIG 2'h1
`define MTC_IDX_COUNT 2'h2
`define MTC_IDX_MODULO 2'h3
`define MTC_ADDR_STATUS_CONTROL 8'h00
`define MTC_ADDR_CLOCK_CONFIG 8'h04
`define MTC_ADDR_COUNT 8'h08
`define MTC_ADDR_MODULO 8'h0c

// Status and control field positions
`define MTC_SC_OVF_BIT 7
`define MTC_SC_IRQEN_BIT 6
`define MTC_SC_CLEAR_BIT 5
`define MTC_SC_HALT_BIT 4

// Clock configuration field positions
`define MTC_CLK_SRC_HI 5
`define MTC_CLK_SRC_LO 4
`define MTC_CLK_PS_HI 3
`define MTC_CLK_PS_LO 0

// Reset values
`define MTC_RST_SRC 2'h0
`define MTC_RST_PS 4'h0
`define MTC_RST_COUNT 8'h00
`define MTC_RST_MODULO 8'h00
`define MTC_RST_HALT 1'b1

// Prescaler and counter limits
`define MTC_PS_MAX 4'h8
`define MTC_PRESCALE_W 8
`define MTC_COUNT_MAX 8'hff

`endif

// ==== pkg/mtc_pkg.sv ====
// Types shared by the modulo timer modules
package mtc_pkg;

    // Clock source selection codes
    typedef enum logic [1:0] {
        MTC_SRC_BUS = 2'b00,
        MTC_SRC_FIXED = 2'b01,
        MTC_SRC_EXT_FALL = 2'b10,
        MTC_SRC_EXT_RISE = 2'b11
    } mtc_src_t;

endpackage

// ==== pkg/mtc_tick_if.sv ====
// Tick path between the clock selector and the counter core
`timescale 1ns/1ns
`default_nettype none

interface mtc_tick_if;
    import mtc_pkg::*;
    logic [1:0] src_sel;    // Selected clock source
    logic fixed_tick;       // Synchronised fixed-frequency clock level
    logic ext_tick;         // Synchronised external tick level
    logic source_pulse;     // One pulse per source edge

    modport selector (
        input src_sel,
        input fixed_tick,
        input ext_tick,
        output source_pulse
    );
    modport core (
        output src_sel,
        output fixed_tick,
        output ext_tick,
        input source_pulse
    );
endinterface

`default_nettype wire

// ==== logic/mtc_source_select.sv ====
// Clock source selector: turns the chosen source into one-cycle pulses
`timescale 1ns/1ns
`default_nettype none

module mtc_source_select
    import mtc_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Tick path
    mtc_tick_if.selector tick
);

    logic fixed_prev_q;   // Last fixed clock level
    logic ext_prev_q;     // Last external level
    logic pulse_d;        // Pulse for the chosen source

    // --------------------------------
    // Edge history
    // --------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fixed_prev_q <= 1'b0;
            ext_prev_q <= 1'b0;
        end else begin
            fixed_prev_q <= tick.fixed_tick;
            ext_prev_q <= tick.ext_tick;
        end
    end

    // --------------------------------
    // Source choice
    // --------------------------------
    always_comb begin
        case (tick.src_sel)
            MTC_SRC_BUS: pulse_d = 1'b1;
            MTC_SRC_FIXED: pulse_d = tick.fixed_tick & ~fixed_prev_q;
            MTC_SRC_EXT_FALL: pulse_d = ~tick.ext_tick & ext_prev_q;
            MTC_SRC_EXT_RISE: pulse_d = tick.ext_tick & ~ext_prev_q;
            default: pulse_d = 1'b0;
        endcase
    end

    assign tick.source_pulse = pulse_d;

endmodule

`default_nettype wire

// ==== logic/mtc_timer.sv ====
// Modulo timer: clock select, prescaler, 8-bit counter and Wishbone registers
//
// Chosen here: the Wishbone register port.
`include "mtc_defines.svh"
`timescale 1ns/1ns
`default_nettype none

module mtc_timer
    import mtc_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Clock source pins
    input wire logic fixed_frequency_clock_i,
    input wire logic external_tick_input_i,
    // Interrupt request
    output logic irq_o
);

    // --------------------------------
    // Declarations
    // --------------------------------
    mtc_tick_if tick ();                 // Tick path to the selector
    logic [1:0] src_q;                   // Clock source select
    logic [3:0] ps_q;                    // Prescale select
    logic [7:0] count_q;                 // Live count
    logic [7:0] modulo_q;                // Modulo value
    logic ovf_q;                         // Overflow flag
    logic ovf_armed_q;                   // Flag read while set
    logic irq_en_q;                      // Overflow interrupt enable
    logic halt_q;                        // Counter halt
    logic [`MTC_PRESCALE_W-1:0] pre_q;   // Prescaler counter
    logic [1:0] fixed_sync_q;            // Fixed clock synchroniser
    logic [1:0] ext_sync_q;              // External tick synchroniser
    logic ack_q;                         // Bus acknowledge
    logic [31:0] rdata_q;                // Read data
    logic access;                        // New bus access
    logic wr_lo;                         // Write with low byte lane
    logic rd;                            // Read access
    logic [1:0] idx;                     // Register index
    logic wr_sc;                         // Status/control write
    logic wr_clk;                        // Clock config write
    logic wr_mod;                        // Modulo write
    logic rd_sc;                         // Status/control read
    logic count_clear;                   // Counter restart
    logic [`MTC_PRESCALE_W-1:0] pre_next; // Prescaler incremented
    logic [3:0] ps_eff;                  // Prescale code after clamp
    logic pre_tick;                      // Prescaled tick
    logic [7:0] wrap_point;              // Terminal count
    logic at_wrap;                       // Count at terminal
    logic cnt_tick;                      // Counter advances
    logic overflow;                      // Overflow event

    // --------------------------------
    // Bus decode
    // --------------------------------
    assign access = cyc_i & stb_i & ~ack_q;
    assign idx = adr_i[3:2];
    // Writes land at the edge where the master samples ack, while the request still stands
    assign wr_lo = cyc_i & stb_i & ack_q & we_i & sel_i[0];
    assign rd = access & ~we_i;
    assign wr_sc = wr_lo & (adr_i == `MTC_ADDR_STATUS_CONTROL);
    assign wr_clk = wr_lo & (adr_i == `MTC_ADDR_CLOCK_CONFIG);
    assign wr_mod = wr_lo & (adr_i == `MTC_ADDR_MODULO);
    assign rd_sc = rd & (adr_i == `MTC_ADDR_STATUS_CONTROL);

    // Acknowledge one cycle after the strobe, every address answered
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= access;
        end
    end

    // Read data, unmapped addresses return zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_q <= 32'h0000_0000;
        end else if (rd) begin
            rdata_q <= 32'h0000_0000;
            if (adr_i[7:4] == 4'h0 && adr_i[1:0] == 2'b00) begin
                case (idx)
                    `MTC_IDX_STATUS_CONTROL: begin
                        rdata_q[`MTC_SC_OVF_BIT] <= ovf_q;
                        rdata_q[`MTC_SC_IRQEN_BIT] <= irq_en_q;
                        rdata_q[`MTC_SC_HALT_BIT] <= halt_q;
                    end
                    `MTC_IDX_CLOCK_CONFIG: begin
                        // Bits 7:6 stay zero
                        rdata_q[7:0] <= {2'b00, src_q, ps_q};
                    end
                    `MTC_IDX_COUNT: begin
                        rdata_q[7:0] <= count_q;
                    end
                    `MTC_IDX_MODULO: begin
                        rdata_q[7:0] <= modulo_q;
                    end
                    default: begin
                        rdata_q <= 32'h0000_0000;
                    end
                endcase
            end
        end
    end

    assign ack_o = ack_q;
    assign dat_o = rdata_q;

    // --------------------------------
    // Control registers
    // --------------------------------
    // Clock configuration; reserved bits not stored
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            src_q <= `MTC_RST_SRC;
            ps_q <= `MTC_RST_PS;
        end else if (wr_clk) begin
            src_q <= dat_i[`MTC_CLK_SRC_HI:`MTC_CLK_SRC_LO];
            ps_q <= dat_i[`MTC_CLK_PS_HI:`MTC_CLK_PS_LO];
        end
    end

    // Interrupt enable and halt bits
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_en_q <= 1'b0;
            halt_q <= `MTC_RST_HALT;
        end else if (wr_sc) begin
            irq_en_q <= dat_i[`MTC_SC_IRQEN_BIT];
            halt_q <= dat_i[`MTC_SC_HALT_BIT];
        end
    end

    // Modulo register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            modulo_q <= `MTC_RST_MODULO;
        end else if (wr_mod) begin
            modulo_q <= dat_i[7:0];
        end
    end

    // --------------------------------
    // Clock source synchronisers
    // --------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fixed_sync_q <= 2'b00;
            ext_sync_q <= 2'b00;
        end else begin
            fixed_sync_q <= {fixed_sync_q[0], fixed_frequency_clock_i};
            ext_sync_q <= {ext_sync_q[0], external_tick_input_i};
        end
    end

    assign tick.src_sel = src_q;
    assign tick.fixed_tick = fixed_sync_q[1];
    assign tick.ext_tick = ext_sync_q[1];

    // Edge detection and source choice
    mtc_source_select u_select (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .tick (tick.selector)
    );

    // --------------------------------
    // Prescaler
    // --------------------------------
    // Clamp codes above eight to the top ratio
    assign ps_eff = (ps_q > `MTC_PS_MAX) ? `MTC_PS_MAX : ps_q;
    assign pre_next = pre_q + `MTC_PRESCALE_W'(1);

    // Tick when all low n bits of the next value roll to zero
    always_comb begin
        if (ps_eff == 4'h0) begin
            pre_tick = tick.source_pulse;
        end else if (ps_eff == `MTC_PS_MAX) begin
            pre_tick = tick.source_pulse & (pre_q == 8'hff);
        end else begin
            pre_tick = tick.source_pulse & ((pre_next & ((8'h01 << ps_eff) - 8'h01)) == 8'h00);
        end
    end

    // Prescaler keeps running through ratio changes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pre_q <= 8'h00;
        end else if (count_clear) begin
            pre_q <= 8'h00;
        end else if (!halt_q && tick.source_pulse) begin
            pre_q <= pre_next;
        end
    end

    // --------------------------------
    // Counter
    // --------------------------------
    assign count_clear = wr_mod | (wr_sc & dat_i[`MTC_SC_CLEAR_BIT]);
    assign wrap_point = (modulo_q == 8'h00) ? `MTC_COUNT_MAX : modulo_q;
    assign at_wrap = (count_q == wrap_point);
    assign cnt_tick = ~halt_q & pre_tick;
    assign overflow = cnt_tick & at_wrap & ~count_clear;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_q <= `MTC_RST_COUNT;
        end else if (count_clear) begin
            count_q <= 8'h00;
        end else if (cnt_tick) begin
            if (at_wrap) begin
                count_q <= 8'h00;
            end else begin
                count_q <= count_q + 8'h01;
            end
        end
    end

    // --------------------------------
    // Overflow flag and interrupt
    // --------------------------------
    // Arm on read while set; a new overflow disarms
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ovf_armed_q <= 1'b0;
        end else if (overflow || count_clear) begin
            ovf_armed_q <= 1'b0;
        end else if (rd_sc && ovf_q) begin
            ovf_armed_q <= 1'b1;
        end else if (wr_sc) begin
            ovf_armed_q <= 1'b0;
        end
    end

    // Set wins over the flag-clear write; a counter restart blocks the set
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ovf_q <= 1'b0;
        end else if (overflow) begin
            ovf_q <= 1'b1;
        end else if (count_clear) begin
            ovf_q <= 1'b0;
        end else if (wr_sc && ovf_armed_q && !dat_i[`MTC_SC_OVF_BIT]) begin
            ovf_q <= 1'b0;
        end
    end

    assign irq_o = ovf_q & irq_en_q;

    // --------------------------------
    // Assertions
    // --------------------------------
    a_reserved_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        ($past(rd) && $past(adr_i) == `MTC_ADDR_CLOCK_CONFIG) |-> dat_o[7:6] == 2'b00)
        else $error("Reserved config bits read nonzero");
    a_count_ro: assert property (@(posedge clk_i) disable iff (rst_i)
        (cyc_i && stb_i && ack_q && we_i && adr_i == `MTC_ADDR_COUNT && !cnt_tick && !count_clear)
        |=> $stable(count_q))
        else $error("Count write changed count");
    a_modulo_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_mod |=> (count_q == 8'h00 && !ovf_q))
        else $error("Modulo write did not clear");
    a_wrap_flag: assert property (@(posedge clk_i) disable iff (rst_i)
        (cnt_tick && at_wrap && !count_clear) |=> (count_q == 8'h00 && ovf_q))
        else $error("Wrap did not clear count and set flag");
    a_count_step: assert property (@(posedge clk_i) disable iff (rst_i)
        (cnt_tick && !at_wrap && !count_clear) |=> count_q == $past(count_q) + 8'h01)
        else $error("Count did not advance by one");
    a_halt_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        (halt_q && !count_clear) |=> $stable(count_q))
        else $error("Count moved while halted");
    a_free_wrap: assert property (@(posedge clk_i) disable iff (rst_i)
        (modulo_q == 8'h00 && cnt_tick && count_q == 8'hff && !count_clear) |=> ovf_q)
        else $error("Free-running wrap missed flag");
    a_flag_kept: assert property (@(posedge clk_i) disable iff (rst_i)
        (ovf_q && !ovf_armed_q && !count_clear) |=> ovf_q)
        else $error("Flag cleared without read first");
    a_irq_follow: assert property (@(posedge clk_i) disable iff (rst_i)
        irq_o == (ovf_q && irq_en_q))
        else $error("Interrupt does not follow flag");
    a_ps_clamp: assert property (@(posedge clk_i) disable iff (rst_i)
        (ps_q > `MTC_PS_MAX) |-> ps_eff == `MTC_PS_MAX)
        else $error("Prescale code not clamped");
    a_bus_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
        (src_q == 2'b00 && ps_q == 4'h0 && !halt_q) |-> cnt_tick)
        else $error("Bus clock source not ticking");
    a_reset_state: assert property (@(posedge clk_i) disable iff (rst_i)
        $past(rst_i) |-> (src_q == `MTC_RST_SRC && ps_q == `MTC_RST_PS && count_q == `MTC_RST_COUNT &&
                          modulo_q == `MTC_RST_MODULO && halt_q == `MTC_RST_HALT))
        else $error("State after reset wrong");
    a_config_keep: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr_clk && !cnt_tick && !count_clear) |=> $stable(count_q))
        else $error("Config write disturbed count");
    a_ext_single: assert property (@(posedge clk_i) disable iff (rst_i)
        (src_q[1] && tick.source_pulse) |=> (!tick.source_pulse || src_q != $past(src_q)))
        else $error("Two pulses for one pin edge");
    a_flag_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(ovf_q) |-> ($past(count_clear) || ($past(wr_sc) && $past(ovf_armed_q))))
        else $error("Flag cleared without cause");
    a_flag_rise: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(ovf_q) |-> ($past(cnt_tick) && $past(at_wrap)))
        else $error("Flag set away from wrap");
    a_count_bound: assert property (@(posedge clk_i) disable iff (rst_i)
        (modulo_q != 8'h00) |-> count_q <= modulo_q)
        else $error("Count beyond modulo");
    a_free_range: assert property (@(posedge clk_i) disable iff (rst_i)
        (modulo_q == 8'h00 && count_q != 8'hff) |=> !$rose(ovf_q))
        else $error("Free-running flag before full range");
    a_pre_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        (halt_q && !count_clear) |=> $stable(pre_q))
        else $error("Prescaler moved while halted");

endmodule

`default_nettype wire

// ==== verification/mtc_timer_tb.sv ====
// Self-checking bench for the modulo timer: registers, sources, prescaler, modulo and flag
`include "mtc_defines.svh"
`timescale 1ns/1ns
`default_nettype none

module mtc_timer_tb;
    import mtc_pkg::*;
    // ----------------------------------------
    // Signals and counters
    // ----------------------------------------
    logic clk_i = 1'b0; // Bus clock
    logic rst_i = 1'b1; // Reset, held at start
    logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0; // Bus request
    logic [7:0] adr_i = 8'h00; // Byte address
    logic [3:0] sel_i = 4'h0; // Byte lanes
    logic [31:0] dat_i = 32'h0; // Write data
    logic [31:0] dat_o; // Read data
    logic ack_o; // Acknowledge
    logic fix_pin = 1'b0; // Fixed clock pin level
    logic ext_pin = 1'b0; // External tick pin level
    logic irq_o; // Interrupt request
    int errors = 0; // Mismatch count
    int num_checks = 0; // Comparison count
    int cycles = 0; // Timeout counter
    localparam int LIMIT = 60000; // Ceiling on run length

    // ----------------------------------------
    // Device under test
    // ----------------------------------------
    mtc_timer uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .fixed_frequency_clock_i(fix_pin), .external_tick_input_i(ext_pin), .irq_o(irq_o));

    // Clock, 20 ns period
    always #10 clk_i = ~clk_i;

    // Hang guard
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == LIMIT) begin
            errors++;
            $display("Error timeout expected %0d seen %0d", LIMIT - 1, cycles);
            conclude();
        end
    end

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("Checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // One classic cycle, entered just after a rising edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [3:0] s,
                      output logic [31:0] q);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        sel_i <= s;
        dat_i <= {24'h0, d};
        @(posedge clk_i);
        while (ack_o !== 1'b1) @(posedge clk_i);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, 4'h1, q);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        wb(1'b0, a, 8'h00, 4'hf, q);
    endtask

    // Halt, clear count and flag, pick a clock setup
    task automatic setup(input logic [7:0] m, input logic [7:0] cfg);
        wr(`MTC_ADDR_STATUS_CONTROL, 8'h10);
        wr(`MTC_ADDR_MODULO, m);
        wr(`MTC_ADDR_CLOCK_CONFIG, cfg);
    endtask

    // Rising edges on one pin, pin left high; slower than a quarter of the bus clock
    task automatic pulses(input bit ext, input int n);
        for (int i = 0; i < n; i++) begin
            if (i > 0) begin
                ext_pin <= 1'b0;
                fix_pin <= 1'b0;
                repeat (4) @(posedge clk_i);
            end
            ext_pin <= ext;
            fix_pin <= ~ext;
            repeat (4) @(posedge clk_i);
        end
        repeat (6) @(posedge clk_i);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        logic [31:0] q;
        repeat (20) @(posedge clk_i);
        rd(`MTC_ADDR_CLOCK_CONFIG, q);
        check("config", q, 32'h00);
        rd(`MTC_ADDR_COUNT, q);
        check("count", q, 32'h00);
        rd(`MTC_ADDR_MODULO, q);
        check("modulo", q, 32'h00);
        rd(`MTC_ADDR_STATUS_CONTROL, q);
        check("status", q, 32'h10);
        check("irq", {31'h0, irq_o}, 32'h0);
        $display("Test reset done");
    endtask

    task automatic t_access();
        logic [31:0] q;
        wr(`MTC_ADDR_CLOCK_CONFIG, 8'hff);
        rd(`MTC_ADDR_CLOCK_CONFIG, q);
        check("config", q, 32'h3f);
        wr(`MTC_ADDR_CLOCK_CONFIG, 8'h00);
        wr(`MTC_ADDR_COUNT, 8'h55);
        rd(`MTC_ADDR_COUNT, q);
        check("count", q, 32'h00);
        wb(1'b1, `MTC_ADDR_MODULO, 8'h33, 4'h0, q);
        rd(`MTC_ADDR_MODULO, q);
        check("modulo", q, 32'h00);
        rd(8'h10, q);
        check("unmapped", q, 32'h00);
        $display("Test access done");
    endtask

    // Prescale codes 0 to 9 and 15 on the bus clock, codes above eight too
    task automatic t_prescale();
        logic [31:0] q;
        int code;
        int div;
        for (int i = 0; i < 11; i++) begin
            code = (i == 10) ? 15 : i;
            div = 1 << ((code > 8) ? 8 : code);
            setup(8'h00, 8'(code));
            wr(`MTC_ADDR_STATUS_CONTROL, 8'h00);
            repeat (div * 20) @(posedge clk_i);
            wr(`MTC_ADDR_STATUS_CONTROL, 8'h10);
            rd(`MTC_ADDR_COUNT, q);
            check("prescaled count", q, 32'(20 + 3 / div));
        end
        $display("Test prescale done");
    endtask

    // Fixed clock and external pin on either edge
    task automatic t_sources();
        logic [31:0] q;
        for (int s = 1; s < 4; s++) begin
            setup(8'h00, 8'(s << 4));
            wr(`MTC_ADDR_STATUS_CONTROL, 8'h00);
            pulses(s != 1, 6);
            wr(`MTC_ADDR_STATUS_CONTROL, 8'h10);
            rd(`MTC_ADDR_COUNT, q);
            check("source count", q, (s == 2) ? 32'h5 : 32'h6);
            fix_pin <= 1'b0;
            ext_pin <= 1'b0;
            repeat (8) @(posedge clk_i);
        end
        $display("Test sources done");
    endtask

    // Ratio and source changes while running keep the count
    task automatic t_change();
        logic [31:0] c1, c2, c3;
        setup(8'h00, 8'h00);
        wr(`MTC_ADDR_STATUS_CONTROL, 8'h00);
        repeat (30) @(posedge clk_i);
        wr(`MTC_ADDR_CLOCK_CONFIG, 8'h08);
        rd(`MTC_ADDR_COUNT, c1);
        check("count kept", 32'(c1 >= 30 && c1 <= 40), 32'h1);
        repeat (40) @(posedge clk_i);
        rd(`MTC_ADDR_COUNT, c2);
        check("slow count", c2, c1);
        wr(`MTC_ADDR_CLOCK_CONFIG, 8'h10);
        repeat (100) @(posedge clk_i);
        rd(`MTC_ADDR_COUNT, c3);
        check("count on switch", c3, c2);
        pulses(1'b0, 3);
        rd(`MTC_ADDR_COUNT, c3);
        check("count continues", c3, c2 + 3);
        wr(`MTC_ADDR_STATUS_CONTROL, 8'h10);
        fix_pin <= 1'b0;
        repeat (8) @(posedge clk_i);
        $display("Test change done");
    endtask

    // Cycles from start until the interrupt, for one modulo value
    task automatic t_wrap(input logic [7:0] m);
        int n;
        setup(m, 8'h00);
        wr(`MTC_ADDR_STATUS_CONTROL, 8'h40);
        n = 0;
        @(negedge clk_i);
        while (irq_o !== 1'b1 && n < 400) begin
            @(negedge clk_i);
            n++;
        end
        @(posedge clk_i);
        check("wrap time", 32'(n + 2 >= int'(m) && n <= int'(m) + 2 + ((m == 0) ? 256 : 0) &&
              n + 2 >= ((m == 0) ? 256 : 0)), 32'h1);
        $display("Test wrap %h done", m);
    endtask

    task automatic irq_chk(input logic e);
        @(negedge clk_i);
        check("irq", {31'h0, irq_o}, {31'h0, e});
        @(posedge clk_i);
    endtask

    // Two-step flag clear and modulo write clearing
    task automatic t_flag();
        logic [31:0] q;
        t_wrap(8'h05);
        wr(`MTC_ADDR_STATUS_CONTROL, 8'h50);
        rd(`MTC_ADDR_COUNT, q);
        check("count bound", 32'(q <= 5), 32'h1);
        rd(`MTC_ADDR_STATUS_CONTROL, q);
        check("flag unarmed", q, 32'hd0);
        wr(`MTC_ADDR_STATUS_CONTROL, 8'h50);
        rd(`MTC_ADDR_STATUS_CONTROL, q);
        check("flag cleared", q, 32'h50);
        irq_chk(1'b0);
        wr(`MTC_ADDR_STATUS_CONTROL, 8'h40);
        repeat (20) @(posedge clk_i);
        // Arm, then let a further overflow land before the clearing write
        rd(`MTC_ADDR_STATUS_CONTROL, q);
        check("flag armed", q, 32'hc0);
        repeat (10) @(posedge clk_i);
        wr(`MTC_ADDR_STATUS_CONTROL, 8'h50);
        irq_chk(1'b1);
        wr(`MTC_ADDR_MODULO, 8'h05);
        rd(`MTC_ADDR_COUNT, q);
        check("count cleared", q, 32'h00);
        rd(`MTC_ADDR_STATUS_CONTROL, q);
        check("flag by modulo", q, 32'h50);
        irq_chk(1'b0);
        // Counter clear bit restarts the count and drops the flag
        wr(`MTC_ADDR_STATUS_CONTROL, 8'h40);
        repeat (20) @(posedge clk_i);
        wr(`MTC_ADDR_STATUS_CONTROL, 8'h70);
        rd(`MTC_ADDR_COUNT, q);
        check("count by clear bit", q, 32'h00);
        rd(`MTC_ADDR_STATUS_CONTROL, q);
        check("flag by clear bit", q, 32'h50);
        irq_chk(1'b0);
        $display("Test flag done");
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_reset();
        t_access();
        t_prescale();
        t_sources();
        t_change();
        t_wrap(8'h00);
        t_flag();
        conclude();
    end
endmodule

`default_nettype wire
